// file: shared/pit_pkg.sv
// constants, types and helpers shared by the serial target and its controller
//
// Overview of operation
// - target never drives the serial clock
// - works at any clock rate, even static
// - one bit per clock, data steady high
// - data change during clock high is control
// - falling data is start, rising is stop
// - idle lines high; transfers begin with start
// - nine clocks per byte, msb first, ack
// - controller ends reads with not-ack then stop
// - repeated start treated as plain start
// - the target acknowledges each byte sent to it
// - ack holds data low over ninth pulse
// - not-ack leaves data high over ninth pulse
// - controller watches acks and reports failures
// - every pointer value is acknowledged
// - seven-bit address follows the start
// - address chosen by strap among two
// - foreign addresses get not-ack, line released
// - target never holds the clock low
// - general call address never acknowledged
// - pointer byte then data to pointed register
// - stop leaves the pointer untouched
package pit_pkg;

    // -------------------------------------------------------------------
    // timing of the controller's clock divider
    // -------------------------------------------------------------------
    localparam int unsigned CLK_NS = 20;
    localparam int unsigned SCL_QTR_NS = 625;
    localparam int unsigned QTR_CYC = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [5:0] QTR_LAST = 6'(QTR_CYC - 1);
    // divider bit that toggles the clock line while reset is held
    localparam int unsigned RST_SCL_BIT = 4;

    // -------------------------------------------------------------------
    // framing and addressing
    // -------------------------------------------------------------------
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [3:0] CNT_FIRST = 4'h1;
    localparam logic [6:0] ADDR_MAIN = 7'h2a; // arbitrary value
    localparam logic [6:0] ADDR_ALT = 7'h3b; // arbitrary value
    localparam logic [6:0] GEN_CALL = 7'h00;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // -------------------------------------------------------------------
    // state machines
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        T_IDLE = 3'h0,
        T_ADDR = 3'h1,
        T_PTR = 3'h3,
        T_WDATA = 3'h2,
        T_RDATA = 3'h6
    } pit_tstate_t;

    typedef enum logic [1:0] {
        H_IDLE = 2'h0,
        H_START = 2'h1,
        H_BIT = 2'h3,
        H_STOP = 2'h2
    } pit_hstate_t;

    typedef enum logic [2:0] {
        S_AWR = 3'h0,
        S_PTR = 3'h1,
        S_WDAT = 3'h3,
        S_ARD = 3'h2,
        S_RDAT = 3'h6
    } pit_step_t;

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    // bit position on the wire, msb first
    function automatic logic [2:0] bit_idx(input logic [3:0] cnt);
        return 3'(4'h7 - cnt);
    endfunction : bit_idx

    function automatic logic addr_hit(input logic [7:0] b, input logic sel);
        logic [6:0] a;
        a = b[7:1];
        return (a != GEN_CALL) && (a == (sel ? ADDR_ALT : ADDR_MAIN));
    endfunction : addr_hit

endpackage : pit_pkg

// file: shared/pit_link_if.sv
// open-drain two-wire link joining the controller and the target
`timescale 1ns/1ns
interface pit_link_if;
    logic scl_oe;
    logic sda_ctrl_oe;
    logic sda_tgt_oe;
    logic scl;
    logic sda;

    // pull-ups: a line is low while any party enables its driver
    assign scl = ~scl_oe;
    assign sda = ~(sda_ctrl_oe | sda_tgt_oe);

    modport ctrl (
        output scl_oe,
        output sda_ctrl_oe,
        input scl,
        input sda
    );

    modport tgt (
        output sda_tgt_oe,
        input scl,
        input sda
    );
endinterface : pit_link_if

// file: logic/pit_target.sv
// serial register-access target, clocked by the link's clock line
`timescale 1ns/1ns
module pit_target
    import pit_pkg::*;
(
    pit_link_if.tgt link,
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_addr_sel,
    input wire logic [7:0] i_rd_data,
    output logic [7:0] o_rd_ptr,
    output logic o_wr_valid,
    output logic [7:0] o_wr_ptr,
    output logic [7:0] o_wr_data
);

    // -------------------------------------------------------------------
    // strap capture in the system domain
    // -------------------------------------------------------------------
    logic [1:0] strap_sync_q;
    logic sel_done_q;
    logic sel_q;

    always_ff @(posedge i_clk_sys) begin
        strap_sync_q <= {strap_sync_q[0], i_addr_sel};
    end

    // caught once, just after reset release, then frozen
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sel_done_q <= 1'b0;
            sel_q <= 1'b0;
        end else if (!sel_done_q) begin
            sel_done_q <= 1'b1;
            sel_q <= strap_sync_q[1];
        end
    end

    // -------------------------------------------------------------------
    // crossings into the link domain
    // -------------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic [1:0] sel_sync_q;
    logic [7:0] rd_s1_q;
    logic [7:0] rd_s2_q;
    logic lrst;

    always_ff @(posedge link.scl) begin
        rst_sync_q <= {rst_sync_q[0], i_rst};
        sel_sync_q <= {sel_sync_q[0], sel_q};
    end

    // read data must be steady while a read byte is loaded
    always_ff @(posedge link.scl) begin
        rd_s1_q <= i_rd_data;
        rd_s2_q <= rd_s1_q;
    end

    assign lrst = rst_sync_q[1];

    // -------------------------------------------------------------------
    // start and stop detection
    // -------------------------------------------------------------------
    // toggles only ever compare against their own copies, so no reset
    logic start_tog_q = 1'b0;
    logic stop_tog_q = 1'b0;
    logic start_n_q = 1'b0;
    logic stop_n_q = 1'b0;
    logic start_seen_q = 1'b0;
    logic stop_seen_q = 1'b0;
    logic start_pend;
    logic stop_pend;

    // a data edge while the clock is high is a condition, not a bit
    always_ff @(negedge link.sda) begin
        if (link.scl) begin
            start_tog_q <= ~start_tog_q;
        end
    end

    always_ff @(posedge link.sda) begin
        if (link.scl) begin
            stop_tog_q <= ~stop_tog_q;
        end
    end

    // the falling clock after a condition has let the toggle settle
    always_ff @(negedge link.scl) begin
        start_n_q <= start_tog_q;
        stop_n_q <= stop_tog_q;
    end

    always_ff @(posedge link.scl) begin
        start_seen_q <= start_n_q;
        stop_seen_q <= stop_n_q;
    end

    assign start_pend = start_n_q ^ start_seen_q;
    assign stop_pend = stop_n_q ^ stop_seen_q;

    // -------------------------------------------------------------------
    // byte framing, sampled on the rising clock
    // -------------------------------------------------------------------
    pit_tstate_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] ptr_q;
    logic [7:0] tx_q;
    logic [7:0] wptr_q;
    logic [7:0] wdat_q;
    logic wr_tog_q;
    logic oe_q;
    logic ack_slot;
    logic ack_want;
    logic hit;

    assign ack_slot = !start_pend && !stop_pend && (st_q != T_IDLE) &&
                      (cnt_q == ACK_BIT);
    assign hit = addr_hit(sh_q, sel_sync_q[1]);

    // no timer anywhere: the clock may stop for any length of time
    always_ff @(posedge link.scl) begin
        if (lrst) begin
            st_q <= T_IDLE;
            cnt_q <= CNT_RST;
            sh_q <= BYTE_RST;
        end else if (start_pend) begin
            st_q <= T_ADDR;
            cnt_q <= CNT_FIRST;
            sh_q <= {sh_q[6:0], link.sda};
        end else if (stop_pend) begin
            st_q <= T_IDLE;
            cnt_q <= CNT_RST;
        end else if (st_q != T_IDLE) begin
            if (cnt_q != ACK_BIT) begin
                sh_q <= {sh_q[6:0], link.sda};
                cnt_q <= cnt_q + 4'h1;
            end else begin
                cnt_q <= CNT_RST;
                case (st_q)
                    T_ADDR: begin
                        if (!hit) begin
                            st_q <= T_IDLE;
                        end else if (sh_q[0]) begin
                            st_q <= T_RDATA;
                        end else begin
                            st_q <= T_PTR;
                        end
                    end
                    T_PTR: begin
                        st_q <= T_WDATA;
                    end
                    T_RDATA: begin
                        if (link.sda) begin
                            st_q <= T_IDLE;
                        end
                    end
                    default: begin
                        st_q <= st_q;
                    end
                endcase
            end
        end
    end

    // pointer survives stop and restart
    always_ff @(posedge link.scl) begin
        if (lrst) begin
            ptr_q <= PTR_RST;
        end else if (ack_slot && st_q == T_PTR) begin
            ptr_q <= sh_q;
        end else if (ack_slot && st_q == T_WDATA) begin
            ptr_q <= ptr_q + 8'h01;
        end
    end

    always_ff @(posedge link.scl) begin
        if (lrst) begin
            wptr_q <= PTR_RST;
            wdat_q <= BYTE_RST;
            wr_tog_q <= 1'b0;
        end else if (ack_slot && st_q == T_WDATA) begin
            wptr_q <= ptr_q;
            wdat_q <= sh_q;
            wr_tog_q <= ~wr_tog_q;
        end
    end

    always_ff @(posedge link.scl) begin
        if (lrst) begin
            tx_q <= BYTE_RST;
        end else if (ack_slot && st_q == T_ADDR && hit && sh_q[0]) begin
            tx_q <= rd_s2_q;
        end else if (ack_slot && st_q == T_RDATA && !link.sda) begin
            tx_q <= rd_s2_q;
        end
    end

    // -------------------------------------------------------------------
    // data line drive, changed on the falling clock
    // -------------------------------------------------------------------
    always_comb begin
        case (st_q)
            T_ADDR: ack_want = hit;
            T_PTR: ack_want = 1'b1;
            T_WDATA: ack_want = 1'b1;
            default: ack_want = 1'b0;
        endcase
    end

    always_ff @(negedge link.scl) begin
        if (lrst) begin
            oe_q <= 1'b0;
        end else if (st_q == T_RDATA && cnt_q != ACK_BIT) begin
            oe_q <= ~tx_q[bit_idx(cnt_q)];
        end else if (cnt_q == ACK_BIT) begin
            oe_q <= ack_want;
        end else begin
            oe_q <= 1'b0;
        end
    end

    // only the data line has a driver here
    assign link.sda_tgt_oe = oe_q;

    // -------------------------------------------------------------------
    // handover to the system domain
    // -------------------------------------------------------------------
    logic [2:0] wr_sync_q;
    logic [7:0] ptr_s1_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            wr_sync_q <= 3'h0;
            o_wr_valid <= 1'b0;
            o_wr_ptr <= PTR_RST;
            o_wr_data <= BYTE_RST;
        end else begin
            wr_sync_q <= {wr_sync_q[1:0], wr_tog_q};
            o_wr_valid <= wr_sync_q[1] ^ wr_sync_q[2];
            if (wr_sync_q[1] ^ wr_sync_q[2]) begin
                o_wr_ptr <= wptr_q;
                o_wr_data <= wdat_q;
            end
        end
    end

    // pointer moves only at ack slots, long before it is used
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ptr_s1_q <= PTR_RST;
            o_rd_ptr <= PTR_RST;
        end else begin
            ptr_s1_q <= ptr_q;
            o_rd_ptr <= ptr_s1_q;
        end
    end

endmodule : pit_target

// file: logic/pit_ctrl.sv
// bus controller that performs single-register writes and reads
`timescale 1ns/1ns
module pit_ctrl
    import pit_pkg::*;
(
    pit_link_if.ctrl link,
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_cmd_valid,
    input wire logic i_cmd_read,
    input wire logic [6:0] i_cmd_addr,
    input wire logic [7:0] i_cmd_ptr,
    input wire logic [7:0] i_cmd_wdata,
    output logic o_cmd_ready,
    output logic o_done,
    output logic o_nack,
    output logic [7:0] o_rd_data
);

    // -------------------------------------------------------------------
    // quarter-bit timer and data line sampling
    // -------------------------------------------------------------------
    // free-running so the clock keeps moving during reset
    logic [5:0] div_q = 6'h00;
    logic tick;
    logic [1:0] sda_sync_q;

    assign tick = (div_q == QTR_LAST);

    always_ff @(posedge i_clk_sys) begin
        div_q <= tick ? 6'h00 : div_q + 6'h01;
    end

    always_ff @(posedge i_clk_sys) begin
        sda_sync_q <= {sda_sync_q[0], link.sda};
    end

    // -------------------------------------------------------------------
    // transfer sequencer
    // -------------------------------------------------------------------
    pit_hstate_t st_q;
    pit_step_t step_q;
    logic [1:0] qtr_q;
    logic [3:0] bit_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic [6:0] addr_q;
    logic [7:0] wdat_q;
    logic [7:0] ptr_q;
    logic [1:0] flush_q;
    logic rd_q;
    logic acked_q;
    logic scl_oe_q;
    logic sda_oe_q;

    always_ff @(posedge i_clk_sys) begin
        o_done <= 1'b0;
        if (i_rst) begin
            st_q <= H_IDLE;
            step_q <= S_AWR;
            qtr_q <= 2'h0;
            bit_q <= CNT_RST;
            tx_q <= BYTE_RST;
            rx_q <= BYTE_RST;
            addr_q <= 7'h00;
            wdat_q <= BYTE_RST;
            ptr_q <= BYTE_RST;
            flush_q <= 2'h3;
            rd_q <= 1'b0;
            acked_q <= 1'b0;
            // clock pulses with data high: the target resets, no condition
            scl_oe_q <= div_q[RST_SCL_BIT];
            sda_oe_q <= 1'b0;
            o_cmd_ready <= 1'b0;
            o_nack <= 1'b0;
            o_rd_data <= BYTE_RST;
        end else begin
            case (st_q)
                H_IDLE: begin
                    sda_oe_q <= 1'b0;
                    if (flush_q != 2'h0) begin
                        // target reset sync only moves on clock edges
                        scl_oe_q <= div_q[RST_SCL_BIT] && !tick;
                        if (tick) begin
                            flush_q <= flush_q - 2'h1;
                        end
                    end else begin
                        scl_oe_q <= 1'b0;
                        o_cmd_ready <= 1'b1;
                    end
                    if (i_cmd_valid && o_cmd_ready) begin
                        o_cmd_ready <= 1'b0;
                        o_nack <= 1'b0;
                        addr_q <= i_cmd_addr;
                        wdat_q <= i_cmd_wdata;
                        rd_q <= i_cmd_read;
                        tx_q <= {i_cmd_addr, 1'b0};
                        step_q <= S_AWR;
                        ptr_q <= i_cmd_ptr;
                        qtr_q <= 2'h0;
                        st_q <= H_START;
                    end
                end
                H_START: if (tick) begin
                    qtr_q <= qtr_q + 2'h1;
                    case (qtr_q)
                        2'h0: sda_oe_q <= 1'b0;
                        2'h1: scl_oe_q <= 1'b0;
                        2'h2: sda_oe_q <= 1'b1;
                        default: begin
                            scl_oe_q <= 1'b1;
                            bit_q <= CNT_RST;
                            st_q <= H_BIT;
                        end
                    endcase
                end
                H_BIT: if (tick) begin
                    qtr_q <= qtr_q + 2'h1;
                    case (qtr_q)
                        2'h0: sda_oe_q <= (bit_q != ACK_BIT) &&
                              (step_q != S_RDAT) && !tx_q[bit_idx(bit_q)];
                        2'h1: scl_oe_q <= 1'b0;
                        2'h2: begin
                            if (bit_q != ACK_BIT) begin
                                rx_q <= {rx_q[6:0], sda_sync_q[1]};
                            end else begin
                                acked_q <= !sda_sync_q[1];
                            end
                        end
                        default: begin
                            scl_oe_q <= 1'b1;
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == ACK_BIT) begin
                                bit_q <= CNT_RST;
                                if (step_q != S_RDAT && !acked_q) begin
                                    o_nack <= 1'b1;
                                    st_q <= H_STOP;
                                end else begin
                                    case (step_q)
                                        S_AWR: begin
                                            step_q <= S_PTR;
                                            tx_q <= ptr_q;
                                        end
                                        S_PTR: begin
                                            if (rd_q) begin
                                                step_q <= S_ARD;
                                                tx_q <= {addr_q, 1'b1};
                                                st_q <= H_START;
                                            end else begin
                                                step_q <= S_WDAT;
                                                tx_q <= wdat_q;
                                            end
                                        end
                                        S_ARD: step_q <= S_RDAT;
                                        S_RDAT: begin
                                            o_rd_data <= rx_q;
                                            st_q <= H_STOP;
                                        end
                                        default: st_q <= H_STOP;
                                    endcase
                                end
                            end
                        end
                    endcase
                end
                H_STOP: if (tick) begin
                    qtr_q <= qtr_q + 2'h1;
                    case (qtr_q)
                        2'h0: sda_oe_q <= 1'b1;
                        2'h1: scl_oe_q <= 1'b0;
                        2'h2: sda_oe_q <= 1'b0;
                        default: begin
                            o_done <= 1'b1;
                            st_q <= H_IDLE;
                        end
                    endcase
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end

    assign link.scl_oe = scl_oe_q;
    assign link.sda_ctrl_oe = sda_oe_q;

endmodule : pit_ctrl

// file: verification/pit_asserts.sv
// checker watching the two-wire link between controller and target
`timescale 1ns/1ns
module pit_asserts
    import pit_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic scl_oe,
    input wire logic sda_ctrl_oe,
    input wire logic sda_tgt_oe,
    input wire logic scl,
    input wire logic sda
);
    // ---------------------------------------------------------------
    // link tracking
    // ---------------------------------------------------------------
    logic scl_q, sda_q, busy_q, acked_q, rw_q;
    logic [1:0] byte_q;
    logic [7:0] arm_q;
    logic [3:0] rise_q;
    logic [7:0] sh_q;
    logic start_w, stop_w, rise_w, last_w;
    assign start_w = scl && scl_q && sda_q && !sda;
    assign stop_w = scl && scl_q && !sda_q && sda;
    assign rise_w = scl && !scl_q;
    assign last_w = rise_w && rise_q == 4'h8;
    // arm delay hides the clock toggling during and just after reset
    always_ff @(posedge i_clk_sys) begin
        scl_q <= scl;
        sda_q <= sda;
        arm_q <= i_rst ? 8'h00 : arm_q + 8'(arm_q != 8'hff);
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || stop_w) begin
            busy_q <= 1'b0;
        end else if (start_w) begin
            busy_q <= 1'b1;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || start_w) begin
            rise_q <= 4'h0;
            byte_q <= 2'h0;
        end else if (rise_w) begin
            rise_q <= (rise_q == 4'h9) ? 4'h1 : rise_q + 4'h1;
            sh_q <= {sh_q[6:0], sda};
            if (last_w && byte_q != 2'h3) begin
                byte_q <= byte_q + 2'h1;
            end
            if (last_w && byte_q == 2'h0) begin
                acked_q <= sda_tgt_oe;
                rw_q <= sh_q[0];
            end
        end
    end
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    a_no_clk_stretch: assert property (!scl |-> scl_oe)
        else $error("clock low without controller");
    a_tgt_edge: assert property ($changed(sda_tgt_oe) |-> $fell(scl))
        else $error("target data moved outside clock fall");
    a_quiet_idle: assert property (!busy_q |-> !sda_tgt_oe)
        else $error("target drives an idle bus");
    a_idle_high: assert property (&arm_q && !busy_q && !start_w
        |-> scl && sda) else $error("idle bus not high");
    a_ack_held: assert property (last_w && sda_tgt_oe
        |-> $past(sda_tgt_oe, 8) ##0 !sda [*8]) else $error("ack not held");
    a_rx_acked: assert property (last_w && byte_q != 2'h0 && acked_q
        && !rw_q |-> sda_tgt_oe) else $error("written byte not acked");
    a_foreign_nack: assert property (last_w && byte_q == 2'h0
        && sh_q[7:1] != ADDR_MAIN && sh_q[7:1] != ADDR_ALT
        |-> !sda_tgt_oe && sda) else $error("foreign address acked");
    a_read_nack_stop: assert property (last_w && byte_q == 2'h1 && rw_q
        && acked_q |-> sda ##[1:300] stop_w) else $error("read not closed");
    c_restart: cover property (busy_q && start_w);
    c_foreign: cover property (last_w && byte_q == 2'h0 && !sda_tgt_oe);
    c_read_end: cover property (last_w && byte_q == 2'h1 && rw_q);
endmodule : pit_asserts

// file: verification/pmic_i2c_target_interface_bench.sv
// self-checking bench: controller and target joined over the link
`timescale 1ns/1ns
module pmic_i2c_target_interface_bench
    import pit_pkg::*;
();
    // ---------------------------------------------------------------
    // signals and instances
    // ---------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sel = 1'b0;
    logic cmd_valid = 1'b0, cmd_read = 1'b0;
    logic [6:0] cmd_addr = 7'h00;
    logic [7:0] cmd_ptr = 8'h00, cmd_wdata = 8'h00;
    logic cmd_ready, done, nack, wr_valid;
    logic [7:0] rd_data, rd_ptr, wr_ptr, wr_data, tgt_rd;
    logic [7:0] mem [256];
    logic [7:0] exp_m [256];
    logic [7:0] exp_p, exp_d, cur_p;
    int n_fail = 0, n_checks = 0, n_wr = 0, cyc = 0;
    int seed = 32'hc3cf;
    assign tgt_rd = mem[rd_ptr];
    initial forever #10 clk = ~clk;
    pit_link_if link ();
    pit_target i_pit_target (.link(link), .i_clk_sys(clk), .i_rst(rst),
        .i_addr_sel(sel), .i_rd_data(tgt_rd), .o_rd_ptr(rd_ptr),
        .o_wr_valid(wr_valid), .o_wr_ptr(wr_ptr), .o_wr_data(wr_data));
    pit_ctrl i_pit_ctrl (.link(link), .i_clk_sys(clk), .i_rst(rst),
        .i_cmd_valid(cmd_valid), .i_cmd_read(cmd_read),
        .i_cmd_addr(cmd_addr), .i_cmd_ptr(cmd_ptr),
        .i_cmd_wdata(cmd_wdata), .o_cmd_ready(cmd_ready), .o_done(done),
        .o_nack(nack), .o_rd_data(rd_data));
    pit_asserts i_pit_asserts (.i_clk_sys(clk), .i_rst(rst),
        .scl_oe(link.scl_oe), .sda_ctrl_oe(link.sda_ctrl_oe),
        .sda_tgt_oe(link.sda_tgt_oe), .scl(link.scl), .sda(link.sda));
    // ---------------------------------------------------------------
    // register file behind the target, timeout
    // ---------------------------------------------------------------
    always @(negedge clk) begin
        if (wr_valid === 1'b1) begin
            n_wr++;
            check(wr_ptr, exp_p);
            check(wr_data, exp_d);
        end
    end
    always @(posedge clk) begin
        if (wr_valid === 1'b1) begin
            mem[wr_ptr] <= wr_data;
        end
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            n_fail++;
            final_report();
        end
    end
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("wrong value at %0t: %h expected %h", $time, seen,
                want);
        end
    endtask : check
    // reset is longer than usual: the target only sees it on clock edges
    task automatic do_reset(input logic s);
        @(posedge clk);
        rst <= 1'b1;
        sel <= s;
        repeat (320) @(posedge clk);
        rst <= 1'b0;
        cur_p = 8'h00;
        @(negedge clk);
        check(rd_ptr, cur_p);
    endtask : do_reset
    task automatic do_cmd(input logic rd, input logic [6:0] a,
            input logic [7:0] p, input logic [7:0] d);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_addr <= a;
        cmd_ptr <= p;
        cmd_wdata <= d;
        do @(negedge clk); while (cmd_ready !== 1'b1);
        @(posedge clk);
        cmd_valid <= 1'b0;
        do @(negedge clk); while (done !== 1'b1);
    endtask : do_cmd
    task automatic wr_chk(input logic [6:0] a, input logic [7:0] p,
            input logic ok);
        int w0;
        w0 = n_wr;
        exp_p = p;
        exp_d = 8'($random(seed));
        do_cmd(1'b0, a, p, exp_d);
        check(8'(nack), 8'(!ok));
        check(8'(n_wr - w0), 8'(ok));
        if (ok) begin
            exp_m[p] = exp_d;
            cur_p = p + 8'h01;
        end
        check(rd_ptr, cur_p);
    endtask : wr_chk
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] p,
            input logic ok);
        do_cmd(1'b1, a, p, 8'h00);
        check(8'(nack), 8'(!ok));
        if (ok) begin
            check(rd_data, exp_m[p]);
            cur_p = p;
        end
        check(rd_ptr, cur_p);
    endtask : rd_chk
    task automatic final_report();
        if (n_fail == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [7:0] p;
        logic [6:0] a;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'($random(seed));
            exp_m[i] = mem[i];
        end
        do_reset(1'b0);
        // edge pointers first: 8'hff also wraps the pointer to zero
        for (int i = 0; i < 5; i++) begin
            p = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            wr_chk(ADDR_MAIN, p, 1'b1);
            rd_chk(ADDR_MAIN, p, 1'b1);
        end
        a = 7'($random(seed));
        if (a == ADDR_MAIN || a == ADDR_ALT) begin
            a = 7'h55;
        end
        wr_chk(ADDR_ALT, p, 1'b0);
        wr_chk(GEN_CALL, p, 1'b0);
        rd_chk(a, p, 1'b0);
        do_reset(1'b1);
        wr_chk(ADDR_ALT, p + 8'h01, 1'b1);
        rd_chk(ADDR_ALT, p + 8'h01, 1'b1);
        wr_chk(ADDR_MAIN, p, 1'b0);
        final_report();
    end
endmodule : pmic_i2c_target_interface_bench
